// file: bsp_consts.vh
// Constants of the boundary-scan test and programming port.
// Included by the port's design files; holds definitions only.
`ifndef BSP_CONSTS_VH
`define BSP_CONSTS_VH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BSP_IR_LEN 4
`define BSP_IR_EXTEST 4'h0
`define BSP_IR_SAMPLE 4'h1
`define BSP_IR_IDCODE 4'h2
`define BSP_IR_PROG 4'h8
`define BSP_IR_BYPASS 4'hF
`define BSP_IR_CAPTURE 4'h1

// ****************************************************************
// Boundary chain layout
// ****************************************************************
`define BSP_NUM_IO 96
`define BSP_NUM_IN 4
`define BSP_NUM_MC 96
`define BSP_IO_BASE 4
`define BSP_MC_BASE 292
`define BSP_CHAIN_LEN 388

// ****************************************************************
// Test pins and programming stream
// ****************************************************************
`define BSP_PIN_TCK 0
`define BSP_PIN_TMS 1
`define BSP_PIN_TDI 2
`define BSP_PIN_TDO 3
`define BSP_PROG_W 8
`define BSP_FIFO_DEPTH 16
`define BSP_FIFO_AW 4

`endif

// file: bsp_mem.v
// Small word memory with a registered read port for the programming FIFO.
// Single clock; read data appear one edge after the address.
`timescale 1ns/1ps
`default_nettype none

module bsp_mem #(
  parameter W = 8,
  parameter AW = 4
) (
  input wire mclk,
  input wire reset_n,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= {W{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule // bsp_mem
`default_nettype wire

// file: bsp_fifo.v
// FIFO for the programming byte stream, valid/ready on both sides.
// Depth must be a power of two; storage lives in bsp_mem.
`timescale 1ns/1ps
`default_nettype none

module bsp_fifo #(
  parameter W = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  wire [AW-1:0] rd_ptr_next;
  wire [AW:0] kept;

  assign in_ready = (count_reg != FULL);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  // Words already stored before this edge; a word written now is read next cycle
  assign kept = pop ? count_reg - 1'b1 : count_reg;

  bsp_mem #(.W(W), .AW(AW)) u_mem (
    .mclk(mclk),
    .reset_n(reset_n),
    .we(push),
    .waddr(wr_ptr_reg),
    .wdata(in_data),
    .raddr(rd_ptr_next),
    .rdata(out_data)
  );

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= kept + {{AW{1'b0}}, push};
      out_valid <= (kept != {(AW+1){1'b0}});
    end
  end

endmodule // bsp_fifo
`default_nettype wire

// file: bsp_tap.v
// Boundary-scan test and programming port: test access port controller,
// boundary chain, identification and bypass registers, programming stream.
// Assumes mclk far faster than the test clock; all pins arrive unsynchronised.
// Operation
// [RL1] No test-reset pin; controller enters reset state at power-up reset.
// [RL2] Instructions SAMPLE/PRELOAD, EXTEST, BYPASS and IDCODE are supported.
// [RL3] Each input pin and I/O pin owns a boundary cell.
// [RL4] Chain covers 96 I/O pins and four dedicated input pins.
// [RL5] Cells hold three capture stages and at most two update stages; input and macrocell cells hold one capture stage.
// [RL6] Separate cell variants for pins and for macrocells.
// [RL7] One serial chain of capture stages from test data in to out.
// [RL8] Capture stages sample, shift, and load update stages on command.
// [RL9] Capture, shift and update controls come from the controller itself.
// [RL10] Programming data enter through the same four test pins.
// [RL11] When disabled, the four test pins are ordinary user I/O.
// [RL12] Pull-up on mode select and data in is a selectable option.
// [RL13] Tester drives the port by the public access port protocol.
// [RL14] Sixteen-state sequence on rising test clock; output changes on falling.
// [RL15] BYPASS uses one bit; IDCODE shifts a 32-bit identification word.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_consts.vh"

module bsp_tap #(
  // Identification word; value is arbitrary, bit 0 set as required
  parameter [31:0] ID_CODE = 32'h0000_0001
) (
  input wire mclk,
  input wire reset_n,
  input wire jtag_en,
  input wire pullup_opt,
  input wire [3:0] jpin_in,
  output reg [3:0] jpin_out,
  output reg [3:0] jpin_oe,
  output reg tms_pullup,
  output reg tdi_pullup,
  output wire [3:0] user_jpin_in,
  input wire [3:0] user_jpin_out,
  input wire [3:0] user_jpin_oe,
  input wire [`BSP_NUM_IO-1:0] pin_in,
  output reg [`BSP_NUM_IO-1:0] pin_out,
  output reg [`BSP_NUM_IO-1:0] pin_oe,
  input wire [`BSP_NUM_IO-1:0] core_out,
  input wire [`BSP_NUM_IO-1:0] core_oe,
  output wire [`BSP_NUM_IO-1:0] core_in,
  input wire [`BSP_NUM_IN-1:0] ded_in,
  output wire [`BSP_NUM_IN-1:0] core_ded_in,
  input wire [`BSP_NUM_MC-1:0] mc_q,
  output wire [`BSP_PROG_W-1:0] prog_data,
  output wire prog_valid,
  input wire prog_ready,
  output wire prog_space
);

  // ****************************************************************
  // Controller states
  // ****************************************************************
  localparam [3:0] ST_RESET = 4'h0;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UPD_IR = 4'hF;

  // Next state from mode select, used by the controller state register
  function [3:0] tap_next;
    input [3:0] s;
    input t;
    begin
      case (s)
        ST_RESET: tap_next = t ? ST_RESET : ST_IDLE;
        ST_IDLE: tap_next = t ? ST_SEL_DR : ST_IDLE;
        ST_SEL_DR: tap_next = t ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = t ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: tap_next = t ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = t ? ST_UPD_DR : ST_PA_DR;
        ST_PA_DR: tap_next = t ? ST_EX2_DR : ST_PA_DR;
        ST_EX2_DR: tap_next = t ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tap_next = t ? ST_SEL_DR : ST_IDLE;
        ST_SEL_IR: tap_next = t ? ST_RESET : ST_CAP_IR;
        ST_CAP_IR: tap_next = t ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: tap_next = t ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = t ? ST_UPD_IR : ST_PA_IR;
        ST_PA_IR: tap_next = t ? ST_EX2_IR : ST_PA_IR;
        ST_EX2_IR: tap_next = t ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: tap_next = t ? ST_SEL_DR : ST_IDLE;
        default: tap_next = ST_RESET;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and test clock edges
  // ****************************************************************
  reg [3:0] jpin_s1_reg;
  reg [3:0] jpin_s2_reg;
  reg tck_prev_reg;
  reg [`BSP_NUM_IO-1:0] pin_s1_reg;
  reg [`BSP_NUM_IO-1:0] pin_s2_reg;
  reg [`BSP_NUM_IN-1:0] ded_s1_reg;
  reg [`BSP_NUM_IN-1:0] ded_s2_reg;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire tck_rise;
  wire tck_fall;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      jpin_s1_reg <= 4'h0;
      jpin_s2_reg <= 4'h0;
      tck_prev_reg <= 1'b0;
      pin_s1_reg <= {`BSP_NUM_IO{1'b0}};
      pin_s2_reg <= {`BSP_NUM_IO{1'b0}};
      ded_s1_reg <= {`BSP_NUM_IN{1'b0}};
      ded_s2_reg <= {`BSP_NUM_IN{1'b0}};
    end else begin
      jpin_s1_reg <= jpin_in;
      jpin_s2_reg <= jpin_s1_reg;
      tck_prev_reg <= tck_s;
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      ded_s1_reg <= ded_in;
      ded_s2_reg <= ded_s1_reg;
    end
  end

  assign tck_s = jpin_s2_reg[`BSP_PIN_TCK];
  assign tms_s = jpin_s2_reg[`BSP_PIN_TMS];
  assign tdi_s = jpin_s2_reg[`BSP_PIN_TDI];
  // Edges count only while the port is enabled; otherwise the pins are user I/O
  assign tck_rise = jtag_en && tck_s && !tck_prev_reg; // RL11
  assign tck_fall = jtag_en && !tck_s && tck_prev_reg;
  assign user_jpin_in = jpin_s2_reg;
  assign core_in = pin_s2_reg;
  assign core_ded_in = ded_s2_reg;

  // ****************************************************************
  // Controller, instruction and data registers
  // ****************************************************************
  reg [3:0] state_reg;
  reg [`BSP_IR_LEN-1:0] ir_reg;
  reg [`BSP_IR_LEN-1:0] ir_sh_reg;
  reg [`BSP_CHAIN_LEN-1:0] bsr_reg;
  reg [`BSP_NUM_IO-1:0] upd_out_reg;
  reg [`BSP_NUM_IO-1:0] upd_oe_reg;
  reg [31:0] id_sh_reg;
  reg byp_reg;
  reg [`BSP_PROG_W-1:0] prog_sh_reg;
  reg prog_push_reg;
  reg prog_ovf_reg;
  reg tdo_reg;
  reg tdo_oe_reg;
  wire sel_bsr;
  wire sel_id;
  wire sel_prog;
  wire extest;
  wire fifo_ready;
  wire ovf_set;
  wire ovf_clr;
  wire [`BSP_CHAIN_LEN-1:0] cap_vec;
  wire [`BSP_NUM_IO-1:0] chain_out;
  wire [`BSP_NUM_IO-1:0] chain_oe;
  reg dr_lsb;

  assign sel_bsr = (ir_reg == `BSP_IR_EXTEST) || (ir_reg == `BSP_IR_SAMPLE); // RL2
  assign sel_id = (ir_reg == `BSP_IR_IDCODE);
  assign sel_prog = (ir_reg == `BSP_IR_PROG); // RL10
  assign extest = jtag_en && (ir_reg == `BSP_IR_EXTEST);

  // Cell layout: input cells first, then three stages per I/O pin, then macrocells
  assign cap_vec[`BSP_NUM_IN-1:0] = ded_s2_reg; // RL3
  genvar g;
  generate
    for (g = 0; g < `BSP_NUM_IO; g = g + 1) begin : g_cell // RL4
      assign cap_vec[`BSP_IO_BASE+3*g] = pin_s2_reg[g]; // RL5
      assign cap_vec[`BSP_IO_BASE+3*g+1] = pin_out[g];
      assign cap_vec[`BSP_IO_BASE+3*g+2] = pin_oe[g];
      assign chain_out[g] = bsr_reg[`BSP_IO_BASE+3*g+1];
      assign chain_oe[g] = bsr_reg[`BSP_IO_BASE+3*g+2];
    end
    for (g = 0; g < `BSP_NUM_MC; g = g + 1) begin : g_mc
      // Macrocell cells only observe; they have no update stage
      assign cap_vec[`BSP_MC_BASE+g] = mc_q[g]; // RL6
    end
  endgenerate

  // Sticky overflow: a byte lost while the FIFO was full; set beats clear
  assign ovf_set = tck_rise && (state_reg == ST_UPD_DR) && sel_prog && !fifo_ready;
  assign ovf_clr = tck_rise && (state_reg == ST_CAP_DR) && sel_prog;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_RESET; // RL1
      ir_reg <= `BSP_IR_IDCODE;
      ir_sh_reg <= `BSP_IR_CAPTURE;
      bsr_reg <= {`BSP_CHAIN_LEN{1'b0}};
      upd_out_reg <= {`BSP_NUM_IO{1'b0}};
      upd_oe_reg <= {`BSP_NUM_IO{1'b0}};
      id_sh_reg <= 32'h0000_0000;
      byp_reg <= 1'b0;
      prog_sh_reg <= {`BSP_PROG_W{1'b0}};
      prog_push_reg <= 1'b0;
      prog_ovf_reg <= 1'b0;
    end else if (!jtag_en) begin
      state_reg <= ST_RESET; // RL11
      ir_reg <= `BSP_IR_IDCODE;
      prog_push_reg <= 1'b0;
    end else begin
      prog_push_reg <= 1'b0;
      prog_ovf_reg <= ovf_set | (prog_ovf_reg & ~ovf_clr);
      if (tck_rise) begin
        state_reg <= tap_next(state_reg, tms_s); // RL14
        case (state_reg)
          ST_RESET: begin
            ir_reg <= `BSP_IR_IDCODE;
          end
          ST_CAP_IR: begin
            ir_sh_reg <= `BSP_IR_CAPTURE;
          end
          ST_SH_IR: begin
            ir_sh_reg <= {tdi_s, ir_sh_reg[`BSP_IR_LEN-1:1]};
          end
          ST_UPD_IR: begin
            ir_reg <= ir_sh_reg;
          end
          ST_CAP_DR: begin
            // RL9
            if (sel_bsr) begin
              bsr_reg <= cap_vec; // RL8
            end else if (sel_id) begin
              id_sh_reg <= ID_CODE; // RL15
            end else if (sel_prog) begin
              prog_sh_reg <= {{(`BSP_PROG_W-2){1'b0}}, prog_ovf_reg, fifo_ready};
            end else begin
              byp_reg <= 1'b0; // RL15
            end
          end
          ST_SH_DR: begin
            if (sel_bsr) begin
              bsr_reg <= {tdi_s, bsr_reg[`BSP_CHAIN_LEN-1:1]}; // RL7
            end else if (sel_id) begin
              id_sh_reg <= {tdi_s, id_sh_reg[31:1]};
            end else if (sel_prog) begin
              prog_sh_reg <= {tdi_s, prog_sh_reg[`BSP_PROG_W-1:1]}; // RL10
            end else begin
              byp_reg <= tdi_s;
            end
          end
          ST_UPD_DR: begin
            if (sel_bsr) begin
              upd_out_reg <= chain_out; // RL8
              upd_oe_reg <= chain_oe;
            end else if (sel_prog) begin
              prog_push_reg <= fifo_ready;
            end
          end
          default: begin
            ir_sh_reg <= ir_sh_reg;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Test data output, changed on the falling test clock edge
  // ****************************************************************
  always @* begin
    if (sel_bsr) begin
      dr_lsb = bsr_reg[0];
    end else if (sel_id) begin
      dr_lsb = id_sh_reg[0];
    end else if (sel_prog) begin
      dr_lsb = prog_sh_reg[0];
    end else begin
      dr_lsb = byp_reg;
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (!jtag_en) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg <= (state_reg == ST_SH_IR) ? ir_sh_reg[0] : dr_lsb; // RL14
      tdo_oe_reg <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      jpin_out <= 4'h0;
      jpin_oe <= 4'h0;
      tms_pullup <= 1'b0;
      tdi_pullup <= 1'b0;
      pin_out <= {`BSP_NUM_IO{1'b0}};
      pin_oe <= {`BSP_NUM_IO{1'b0}};
    end else begin
      if (jtag_en) begin
        jpin_out <= {tdo_reg, 3'h0};
        jpin_oe <= {tdo_oe_reg, 3'h0};
      end else begin
        jpin_out <= user_jpin_out; // RL11
        jpin_oe <= user_jpin_oe;
      end
      tms_pullup <= jtag_en && pullup_opt; // RL12
      tdi_pullup <= jtag_en && pullup_opt;
      pin_out <= extest ? upd_out_reg : core_out; // RL2
      pin_oe <= extest ? upd_oe_reg : core_oe;
    end
  end

  // ****************************************************************
  // Programming byte stream
  // ****************************************************************
  bsp_fifo #(
    .W(`BSP_PROG_W),
    .DEPTH(`BSP_FIFO_DEPTH),
    .AW(`BSP_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(prog_push_reg),
    .in_ready(fifo_ready),
    .in_data(prog_sh_reg),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_data)
  );

  assign prog_space = fifo_ready;

endmodule // bsp_tap
`default_nettype wire

// file: bsp_tap_properties.sv
// Checker for the boundary-scan test port, bound to bsp_tap.
// Assumes every input changes just after a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module bsp_tap_props (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic jtag_en,
  input wire logic pullup_opt,
  input wire logic [3:0] jpin_in,
  input wire logic [3:0] jpin_out,
  input wire logic [3:0] jpin_oe,
  input wire logic tms_pullup,
  input wire logic tdi_pullup,
  input wire logic [3:0] user_jpin_out,
  input wire logic [3:0] user_jpin_oe,
  input wire logic [95:0] pin_in,
  input wire logic [95:0] pin_out,
  input wire logic [95:0] pin_oe,
  input wire logic [95:0] core_out,
  input wire logic [95:0] core_oe,
  input wire logic [95:0] core_in,
  input wire logic [3:0] ded_in,
  input wire logic [3:0] core_ded_in,
  input wire logic [7:0] prog_data,
  input wire logic prog_valid,
  input wire logic prog_ready,
  input wire logic prog_space
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ****************
  // Cycles since the raw test clock pin last fell
  // ****************
  logic tck_d;
  logic [3:0] since_fall;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tck_d <= 1'b0;
      since_fall <= 4'hF;
    end else begin
      tck_d <= jpin_in[0];
      if (tck_d && !jpin_in[0]) since_fall <= 4'h0;
      else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
    end
  end
  a_pullup_level: assert property (reset_n [*2] |->
    tms_pullup == $past(jtag_en && pullup_opt) && tdi_pullup == tms_pullup)
    else $error("pull-up level wrong");
  a_user_pins_out: assert property (!jtag_en [*2] |->
    jpin_out == $past(user_jpin_out) && jpin_oe == $past(user_jpin_oe))
    else $error("user drive of test pins wrong");
  a_test_pins_idle: assert property (jtag_en [*2] |->
    jpin_out[2:0] == 3'h0 && jpin_oe[2:0] == 3'h0)
    else $error("test input pins driven");
  a_pins_follow_core: assert property (!jtag_en [*3] |->
    pin_out == $past(core_out) && pin_oe == $past(core_oe))
    else $error("pads do not follow core");
  a_input_sync: assert property (reset_n [*3] |->
    core_in == $past(pin_in, 2) && core_ded_in == $past(ded_in, 2))
    else $error("input synchroniser depth wrong");
  a_tdo_on_fall: assert property (($changed(jpin_out[3]) || $changed(jpin_oe[3]))
    && jtag_en && $past(jtag_en, 2) |-> since_fall inside {[2:7]})
    else $error("data out moved away from a falling edge");
  a_prog_hold: assert property (prog_valid && !prog_ready |=>
    prog_valid && $stable(prog_data))
    else $error("stalled byte not held");
  a_pop_frees: assert property (prog_valid && prog_ready && !prog_space |=>
    prog_space)
    else $error("pop from full buffer left no space");
  a_full_has_data: assert property (!prog_space |-> prog_valid)
    else $error("full buffer shows no data");
  c_pop: cover property (prog_valid && prog_ready);
  c_full: cover property (!prog_space);
  c_tdo_drive: cover property ($rose(jpin_oe[3]));
endmodule // bsp_tap_props

bind bsp_tap bsp_tap_props bsp_tap_props_inst (.mclk, .reset_n, .jtag_en, .pullup_opt,
  .jpin_in, .jpin_out, .jpin_oe, .tms_pullup, .tdi_pullup, .user_jpin_out, .user_jpin_oe,
  .pin_in, .pin_out, .pin_oe, .core_out, .core_oe, .core_in, .ded_in, .core_ded_in,
  .prog_data, .prog_valid, .prog_ready, .prog_space);
`default_nettype wire

// file: bsp_tester.sv
// Boundary-scan tester model driving test clock, mode select and data in.
// Assumes calls back to back; the test clock rests low between calls.
`timescale 1ns/1ps
`default_nettype none
module bsp_tester (
  input wire logic mclk,
  input wire logic tdo,
  output var logic tck,
  output var logic tms,
  output var logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // ****************
  // One 160 ns test clock: low 4 mclk, high 4 mclk
  // ****************
  task automatic clk_bit(input logic m, input logic din, output logic q);
    @(posedge mclk);
    tms <= m;
    tdi <= din;
    repeat (3) @(posedge mclk);
    tck <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 q = tdo;
    @(posedge mclk);
    tck <= 1'b0;
  endtask
endmodule // bsp_tester
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the boundary-scan test port.
// Tester model drives the link; the bench drives core side and drain.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_consts.vh"
module testbench;
  // Arbitrary identification word
  localparam logic [31:0] ID = 32'h2468ACE1;
  logic mclk, reset_n, jtag_en, pullup_opt, prog_ready, q;
  logic prog_valid, prog_space, tms_pullup, tdi_pullup, tck, tms, tdi;
  logic [3:0] user_jpin_out, user_jpin_oe, user_jpin_in, ded_in, core_ded_in, jpin_out, jpin_oe;
  logic [95:0] pin_in, pin_out, pin_oe, core_out, core_oe, core_in, mc_q;
  logic [7:0] prog_data;
  logic [387:0] d, r;
  logic [7:0] fifo_q[$];
  int n_errors, check_count, seed, k;
  wire [3:0] jpin_in;
  assign jpin_in = (jpin_oe & jpin_out) | (~jpin_oe & {~jpin_out[3], tdi, tms, tck});
  bsp_tap #(.ID_CODE(ID)) bsp_tap_inst (.mclk, .reset_n, .jtag_en, .pullup_opt, .jpin_in,
    .jpin_out, .jpin_oe, .tms_pullup, .tdi_pullup, .user_jpin_in, .user_jpin_out,
    .user_jpin_oe, .pin_in, .pin_out, .pin_oe, .core_out, .core_oe, .core_in, .ded_in,
    .core_ded_in, .mc_q, .prog_data, .prog_valid, .prog_ready, .prog_space);
  bsp_tester bsp_tester_inst (.mclk, .tdo(jpin_in[3]), .tck, .tms, .tdi);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****************
  // Helpers
  // ****************
  task automatic chk(input string nm, input logic [387:0] e, input logic [387:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic scan(input logic ir, input int n, input logic [387:0] din);
    logic b;
    bsp_tester_inst.clk_bit(1'b1, 1'b0, b);
    if (ir) bsp_tester_inst.clk_bit(1'b1, 1'b0, b);
    repeat (2) bsp_tester_inst.clk_bit(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      bsp_tester_inst.clk_bit(i == n - 1, din[i], b);
      d[i] = b;
    end
    bsp_tester_inst.clk_bit(1'b1, 1'b0, b);
    bsp_tester_inst.clk_bit(1'b0, 1'b0, b);
  endtask
  function automatic logic [387:0] rnd();
    repeat (13) rnd = {rnd[355:0], $random(seed)};
  endfunction
  function automatic logic [387:0] chain_exp();
    logic [387:0] e;
    e = '0;
    e[3:0] = ded_in;
    for (int i = 0; i < 96; i++) begin
      e[4 + 3 * i] = pin_in[i];
      e[5 + 3 * i] = core_out[i];
      e[6 + 3 * i] = core_oe[i];
      e[292 + i] = mc_q[i];
    end
    return e;
  endfunction
  function automatic logic [95:0] pick(input logic [387:0] v, input int off);
    for (int i = 0; i < 96; i++) pick[i] = v[off + 3 * i];
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Whole run needs under 12000 mclk; allow about three times that
  initial begin
    #700000;
    n_errors++;
    close_out();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    seed = 32'hb71c;
    n_errors = 0;
    check_count = 0;
    d = '0;
    reset_n = 1'b0;
    jtag_en = 1'b1;
    pullup_opt = 1'b1;
    prog_ready = 1'b0;
    user_jpin_out = 4'h0;
    user_jpin_oe = 4'h0;
    {ded_in, pin_in, core_out, core_oe, mc_q} = '0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    r = rnd();
    {mc_q, core_oe, core_out, pin_in, ded_in} <= r;
    repeat (4) @(posedge mclk);
    bsp_tester_inst.clk_bit(1'b0, 1'b0, q);
    scan(1'b0, 32, '0);
    chk("idcode", ID, d[31:0]);
    chk("pullup", 2'b11, {tms_pullup, tdi_pullup});
    $display("test idcode done");
    for (k = 0; k < 2; k++) begin
      scan(1'b1, 4, k ? `BSP_IR_BYPASS : 4'h9);
      chk("ir_capture", `BSP_IR_CAPTURE, d[3:0]);
      r = rnd();
      scan(1'b0, 16, r);
      chk("bypass", {r[14:0], 1'b0}, d[15:0]);
    end
    repeat (5) bsp_tester_inst.clk_bit(1'b1, 1'b0, q);
    bsp_tester_inst.clk_bit(1'b0, 1'b0, q);
    scan(1'b0, 32, '0);
    chk("idcode_again", ID, d[31:0]);
    $display("test bypass done");
    scan(1'b1, 4, `BSP_IR_SAMPLE);
    r = rnd();
    scan(1'b0, `BSP_CHAIN_LEN, r);
    chk("sample", chain_exp(), d);
    scan(1'b1, 4, `BSP_IR_EXTEST);
    repeat (3) @(posedge mclk);
    chk("extest_out", pick(r, 5), pin_out);
    chk("extest_oe", pick(r, 6), pin_oe);
    $display("test sample extest done");
    scan(1'b1, 4, `BSP_IR_PROG);
    for (k = 0; k < 18; k++) begin
      r = rnd();
      scan(1'b0, 8, r);
      if (k < 16) fifo_q.push_back(r[7:0]);
      if (k == 0) chk("prog_cap", 8'h01, d[7:0]);
      if (k == 17) chk("prog_over", 8'h02, d[7:0]);
    end
    chk("prog_full", 1'b0, prog_space);
    for (k = 0; k < 400 && fifo_q.size() > 0; k++) begin
      @(posedge mclk);
      prog_ready <= 1'($random(seed));
      #1;
      if (prog_valid === 1'b1 && prog_ready) chk("prog_data", fifo_q.pop_front(), prog_data);
    end
    @(posedge mclk);
    prog_ready <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("prog_empty", {1'b1, 1'b0, 32'h0}, {prog_space, prog_valid, fifo_q.size()});
    $display("test programming done");
    pullup_opt <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("pullup_opt_off", 2'b00, {tms_pullup, tdi_pullup});
    r = rnd();
    jtag_en <= 1'b0;
    pullup_opt <= 1'b1;
    user_jpin_out <= r[3:0];
    user_jpin_oe <= r[7:4];
    repeat (4) @(posedge mclk);
    #1;
    chk("user_pins", r[7:0], {jpin_oe, jpin_out});
    chk("user_in", jpin_in, user_jpin_in);
    chk("pullup_off", 2'b00, {tms_pullup, tdi_pullup});
    $display("test disabled port done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
